// >>> hdl/pixel_output_processing_map.svh
// register offsets, reset values and fixed counts of the pixel output path
`ifndef PIXEL_OUTPUT_PROCESSING_MAP_SVH
`define PIXEL_OUTPUT_PROCESSING_MAP_SVH
`define ADDR_OUTPUT_WORD_WIDTH 7'h07
`define ADDR_SERIAL_BIT_ORDER 7'h0a
`define ADDR_GAIN_EVEN_ROW_EVEN_COL 7'h1e
`define ADDR_GAIN_EVEN_ROW_ODD_COL 7'h1f
`define ADDR_GAIN_ODD_ROW_EVEN_COL 7'h20
`define ADDR_GAIN_ODD_ROW_ODD_COL 7'h21
`define ADDR_TARGET_BLACK_LEVEL 7'h3a
`define ADDR_SQUEEZE_ENABLE 7'h41
`define ADDR_SQUEEZE_KNEE_LEVEL 7'h42
`define ADDR_SQUEEZE_DIVISOR_SELECT 7'h44
`define ADDR_BLACK_AUTO_BYPASS 7'h5d
`define ADDR_FIXED_ADC_BLACK_LEVEL 7'h5e
`define RST_OUTPUT_WORD_WIDTH 2'h2
`define RST_SERIAL_BIT_ORDER 1'h0
`define RST_GAIN 8'h0f
`define RST_TARGET_BLACK_LEVEL 13'h001e
`define RST_SQUEEZE_ENABLE 1'h0
`define RST_SQUEEZE_KNEE_LEVEL 13'h0000
`define RST_SQUEEZE_DIVISOR_SELECT 2'h0
`define RST_BLACK_AUTO_BYPASS 1'h0
`define RST_FIXED_ADC_BLACK_LEVEL 13'h0000
`define WIDTH_CODE_10 2'h1
`define WIDTH_CODE_12 2'h2
`define MAX_10_BIT 13'h03ff
`define MAX_12_BIT 13'h0fff
`define MAX_13_BIT 13'h1fff
`define UNITY_GAIN 8'h0f
`define BLACK_SAMPLE_SHIFT 4
`define BLACK_SAMPLE_LAST 5'h0f
`define GAIN_SHIFT 4
`define FIFO_DEPTH 8
`define FIFO_WIDTH 17
`endif

// >>> hdl/pixel_output_processing_pkg.sv
// types shared by the pixel output path
package pixel_output_processing_pkg;
   typedef enum logic [0:0] {ST_RUN, ST_PAD} lane_state_e;
   typedef logic [12:0] pixel_t;
endpackage

// >>> hdl/pixel_output_processing.sv
// pixel output path: black mapping, parity gain, knee squeeze, lane split, serialiser
// Functional notes
// - spread row region over used lanes, ascending column order on each lane
// - bit-order setting picks lsb-first or msb-first serial transmission
// - bit order acts only within a pixel word, same for either width
// - output equals adc value minus adc black plus target, clipped to range
// - target black level is a 13-bit value; controller should program at least 30
// - bypass clear: adc black level measured per row from shielded pixels
// - bypass set: fixed 13-bit value used as constant adc black level
// - four gains chosen by row and column parity of the pixel
// - gain equals setting plus one, divided by sixteen
// - setting 15 is unity, 255 sixteen-fold, 0 one-sixteenth
// - gain applied after black level correction
// - one enable bit switches squeeze off when clear, on when set
// - values up to knee pass unchanged, excess above knee divided by ratio
// - divisor select 0..3 gives ratio 2, 4, 8, 16
// - width code 1 gives 10-bit, 2 gives 12-bit; controller never writes 0
// - equal pixel count per lane; last lane pads dummy pixels when short
// - with n lanes selected, lanes 0 to n-1 are used
`timescale 1ns/100ps
`include "pixel_output_processing_map.svh"

module pixel_fifo
#(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WIDTH-1:0] wr_data_in,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] fill;
   wire push = wr_valid_in && wr_ready_out;
   wire pop = rd_valid_out && rd_ready_in;
   assign wr_ready_out = (fill != DEPTH[AW:0]);
   assign rd_valid_out = (fill != '0);
   assign rd_data_out = mem[rd_ptr];

   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem[wr_ptr] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            fill <= fill + 1'b1;
         else if (pop && !push)
            fill <= fill - 1'b1;
      end
   end
endmodule // pixel_fifo

module pixel_output_processing
   import pixel_output_processing_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic [12:0] reg_wdata_in,
   output logic [12:0] reg_rdata_out,
   input wire logic [13:0] pixels_per_channel_in,
   input wire logic [3:0] used_channel_count_in,
   input wire logic shield_valid_in,
   input wire logic [12:0] shield_data_in,
   input wire logic pix_valid_in,
   output logic pix_ready_out,
   input wire logic [12:0] pix_data_in,
   input wire logic pix_row_odd_in,
   input wire logic pix_col_odd_in,
   input wire logic pix_row_last_in,
   output logic serial_bit_out,
   output logic serial_valid_out,
   output logic serial_word_start_out,
   output logic serial_dummy_out,
   output logic [3:0] pixel_serial_lane_out
);
   logic [1:0] output_word_width;
   logic serial_bit_order;
   logic [12:0] target_black_level;
   logic squeeze_enable;
   logic [12:0] squeeze_knee_level;
   logic [1:0] squeeze_divisor_select;
   logic black_auto_bypass;
   logic [12:0] fixed_adc_black_level;
   logic [7:0] parity_channel_gain [4];

   // register port
   wire sel_width = (reg_addr_in == `ADDR_OUTPUT_WORD_WIDTH);
   wire sel_order = (reg_addr_in == `ADDR_SERIAL_BIT_ORDER);
   wire sel_target = (reg_addr_in == `ADDR_TARGET_BLACK_LEVEL);
   wire sel_sq_en = (reg_addr_in == `ADDR_SQUEEZE_ENABLE);
   wire sel_knee = (reg_addr_in == `ADDR_SQUEEZE_KNEE_LEVEL);
   wire sel_div = (reg_addr_in == `ADDR_SQUEEZE_DIVISOR_SELECT);
   wire sel_bypass = (reg_addr_in == `ADDR_BLACK_AUTO_BYPASS);
   wire sel_fixed = (reg_addr_in == `ADDR_FIXED_ADC_BLACK_LEVEL);
   wire sel_gain_any = (reg_addr_in >= `ADDR_GAIN_EVEN_ROW_EVEN_COL) &&
                       (reg_addr_in <= `ADDR_GAIN_ODD_ROW_ODD_COL);
   wire [1:0] gain_index = 2'(reg_addr_in - `ADDR_GAIN_EVEN_ROW_EVEN_COL);
   logic [12:0] read_mux;

   always_comb
   begin
      read_mux = 13'h0000;
      if (sel_width)
         read_mux = {11'h000, output_word_width};
      else if (sel_order)
         read_mux = {12'h000, serial_bit_order};
      else if (sel_target)
         read_mux = target_black_level;
      else if (sel_sq_en)
         read_mux = {12'h000, squeeze_enable};
      else if (sel_knee)
         read_mux = squeeze_knee_level;
      else if (sel_div)
         read_mux = {11'h000, squeeze_divisor_select};
      else if (sel_bypass)
         read_mux = {12'h000, black_auto_bypass};
      else if (sel_fixed)
         read_mux = fixed_adc_black_level;
      else if (sel_gain_any)
         read_mux = {5'h00, parity_channel_gain[gain_index]};
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         output_word_width <= `RST_OUTPUT_WORD_WIDTH;
         serial_bit_order <= `RST_SERIAL_BIT_ORDER;
         target_black_level <= `RST_TARGET_BLACK_LEVEL;
         squeeze_enable <= `RST_SQUEEZE_ENABLE;
         squeeze_knee_level <= `RST_SQUEEZE_KNEE_LEVEL;
         squeeze_divisor_select <= `RST_SQUEEZE_DIVISOR_SELECT;
         black_auto_bypass <= `RST_BLACK_AUTO_BYPASS;
         fixed_adc_black_level <= `RST_FIXED_ADC_BLACK_LEVEL;
         reg_rdata_out <= 13'h0000;
      end
      else
      begin
         if (reg_rd_in)
            reg_rdata_out <= read_mux;
         if (reg_wr_in && sel_width)
            output_word_width <= reg_wdata_in[1:0];
         if (reg_wr_in && sel_order)
            serial_bit_order <= reg_wdata_in[0];
         if (reg_wr_in && sel_target)
            target_black_level <= reg_wdata_in;
         if (reg_wr_in && sel_sq_en)
            squeeze_enable <= reg_wdata_in[0];
         if (reg_wr_in && sel_knee)
            squeeze_knee_level <= reg_wdata_in;
         if (reg_wr_in && sel_div)
            squeeze_divisor_select <= reg_wdata_in[1:0];
         if (reg_wr_in && sel_bypass)
            black_auto_bypass <= reg_wdata_in[0];
         if (reg_wr_in && sel_fixed)
            fixed_adc_black_level <= reg_wdata_in;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_gain
         always_ff @(posedge clk_in or negedge resetn_in)
         begin
            if (!resetn_in)
               parity_channel_gain[gi] <= `RST_GAIN;
            else if (reg_wr_in && sel_gain_any && gain_index == 2'(gi))
               parity_channel_gain[gi] <= reg_wdata_in[7:0];
         end
      end
   endgenerate

   // per-row black level from shielded samples; a short row keeps the old level
   logic [16:0] shield_sum;
   logic [4:0] shield_count;
   logic [12:0] black_auto;
   wire [16:0] shield_sum_next = shield_sum + {4'h0, shield_data_in};
   wire shield_done = shield_valid_in && (shield_count == `BLACK_SAMPLE_LAST);

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         shield_sum <= 17'h0_0000;
         shield_count <= 5'h00;
         black_auto <= 13'h0000;
      end
      else if (shield_valid_in)
      begin
         shield_sum <= shield_done ? 17'h0_0000 : shield_sum_next;
         shield_count <= shield_done ? 5'h00 : shield_count + 5'h01;
         if (shield_done)
            black_auto <= shield_sum_next[`BLACK_SAMPLE_SHIFT +: 13];
      end
   end

   wire [12:0] black_adc = black_auto_bypass ? fixed_adc_black_level : black_auto;

   // stage 1: black mapping with clip; signed arithmetic keeps the underflow visible
   wire signed [14:0] mapped = $signed({2'b00, pix_data_in}) - $signed({2'b00, black_adc})
                               + $signed({2'b00, target_black_level});
   wire [12:0] mapped_clip = mapped[14] ? 13'h0000 :
                             (mapped[13] ? `MAX_13_BIT : mapped[12:0]);
   logic s1_val;
   logic [12:0] s1_data;
   logic [1:0] s1_parity;
   logic s1_last;
   lane_state_e state;
   logic [13:0] lane_cnt;
   logic [3:0] lane_idx;
   wire fifo_wr_ready;
   wire take_in = pix_valid_in && pix_ready_out;
   wire s1_fire = s1_val && fifo_wr_ready && (state == ST_RUN);

   // stage 2 (combinational): gain after black mapping, squeeze, width clip
   wire [8:0] gain_factor = {1'b0, parity_channel_gain[s1_parity]} + 9'h001;
   wire [21:0] gain_product = s1_data * gain_factor;
   wire [17:0] gain_scaled = gain_product[21:`GAIN_SHIFT];
   wire [12:0] gain_clip = (gain_scaled > {5'h00, `MAX_13_BIT}) ? `MAX_13_BIT :
                           gain_scaled[12:0];
   wire [12:0] excess = gain_clip - squeeze_knee_level;
   wire [3:0] div_shift = {2'b00, squeeze_divisor_select} + 4'h1;
   wire [12:0] squeezed = (squeeze_enable && gain_clip > squeeze_knee_level) ?
                          squeeze_knee_level + (excess >> div_shift) : gain_clip;
   wire [12:0] width_max = (output_word_width == `WIDTH_CODE_10) ? `MAX_10_BIT : `MAX_12_BIT;
   wire [12:0] out_pixel = (squeezed > width_max) ? width_max : squeezed;

   // lane allocation at the fifo input
   wire lane_full = (lane_cnt == pixels_per_channel_in - 14'h0001);
   wire lane_top = (lane_idx == used_channel_count_in - 4'h1);
   wire pad_push = (state == ST_PAD) && fifo_wr_ready;
   wire fifo_push = s1_fire || pad_push;
   // pad words carry zero so a stale pixel never leaks onto the padded lane
   wire [11:0] lane_word = (state == ST_PAD) ? 12'h000 : out_pixel[11:0];
   wire [16:0] fifo_wr_data = {(state == ST_PAD), lane_idx, lane_word};
   lane_state_e next_state;
   logic next_s1_val;

   always_comb
   begin
      next_state = state;
      if (state == ST_RUN && s1_fire && s1_last && !lane_full)
         next_state = ST_PAD;
      else if (state == ST_PAD && pad_push && lane_full)
         next_state = ST_RUN;
      next_s1_val = take_in ? 1'b1 : (s1_fire ? 1'b0 : s1_val);
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         s1_val <= 1'b0;
         s1_data <= 13'h0000;
         s1_parity <= 2'h0;
         s1_last <= 1'b0;
         pix_ready_out <= 1'b0;
         state <= ST_RUN;
      end
      else
      begin
         s1_val <= next_s1_val;
         state <= next_state;
         // half-rate acceptance keeps the ready output a flop without a skid buffer
         pix_ready_out <= !next_s1_val && (next_state == ST_RUN);
         if (take_in)
         begin
            s1_data <= mapped_clip;
            s1_parity <= {pix_row_odd_in, pix_col_odd_in};
            s1_last <= pix_row_last_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         lane_cnt <= 14'h0000;
         lane_idx <= 4'h0;
      end
      else if (fifo_push)
      begin
         if ((s1_fire && s1_last && lane_full) || (pad_push && lane_full))
         begin
            lane_cnt <= 14'h0000;
            lane_idx <= 4'h0;
         end
         else if (lane_full)
         begin
            lane_cnt <= 14'h0000;
            if (!lane_top)
               lane_idx <= lane_idx + 4'h1;
         end
         else
            lane_cnt <= lane_cnt + 14'h0001;
      end
   end

   wire fifo_rd_valid;
   logic fifo_rd_ready;
   wire [16:0] fifo_rd_data;

   pixel_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo
   (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .wr_valid_in(fifo_push),
      .wr_ready_out(fifo_wr_ready),
      .wr_data_in(fifo_wr_data),
      .rd_valid_out(fifo_rd_valid),
      .rd_ready_in(fifo_rd_ready),
      .rd_data_out(fifo_rd_data)
   );

   // serialiser: one bit per clock, word length from the width code
   logic busy;
   logic [11:0] cur_word;
   logic [3:0] bit_idx;
   wire [3:0] word_bits = (output_word_width == `WIDTH_CODE_10) ? 4'ha : 4'hc;
   wire [3:0] last_idx = word_bits - 4'h1;
   wire [3:0] pick_idx = serial_bit_order ? (last_idx - bit_idx) : bit_idx;
   assign fifo_rd_ready = !busy;

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         busy <= 1'b0;
         cur_word <= 12'h000;
         bit_idx <= 4'h0;
         serial_bit_out <= 1'b0;
         serial_valid_out <= 1'b0;
         serial_word_start_out <= 1'b0;
         serial_dummy_out <= 1'b0;
         pixel_serial_lane_out <= 4'h0;
      end
      else
      begin
         serial_word_start_out <= 1'b0;
         if (!busy && fifo_rd_valid)
         begin
            busy <= 1'b1;
            cur_word <= fifo_rd_data[11:0];
            serial_dummy_out <= fifo_rd_data[16];
            pixel_serial_lane_out <= fifo_rd_data[15:12];
            bit_idx <= 4'h0;
            serial_valid_out <= 1'b0;
         end
         else if (busy)
         begin
            serial_bit_out <= cur_word[pick_idx];
            serial_valid_out <= 1'b1;
            serial_word_start_out <= (bit_idx == 4'h0);
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == last_idx)
               busy <= 1'b0;
         end
         else
            serial_valid_out <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   property p_black_fixed;
      black_auto_bypass |-> black_adc == fixed_adc_black_level;
   endproperty
   a_black_fixed: assert property (p_black_fixed) else $error("bypass black level wrong");

   property p_black_auto;
      shield_done && !black_auto_bypass |=> black_adc == $past(shield_sum_next[16:4]);
   endproperty
   a_black_auto: assert property (p_black_auto) else $error("auto black level wrong");

   property p_lane_range;
      fifo_push |-> lane_idx < used_channel_count_in;
   endproperty
   a_lane_range: assert property (p_lane_range) else $error("lane beyond used count");

   property p_pad_dummy;
      state == ST_PAD |-> !s1_fire && fifo_wr_data[16] && fifo_wr_data[11:0] == 12'h000;
   endproperty
   a_pad_dummy: assert property (p_pad_dummy) else $error("pad word not dummy");

   property p_width_clip;
      fifo_push && !fifo_wr_data[16] |-> out_pixel <= width_max;
   endproperty
   a_width_clip: assert property (p_width_clip) else $error("pixel above width range");

   property p_unity;
      s1_val && parity_channel_gain[s1_parity] == `UNITY_GAIN |-> gain_clip == s1_data;
   endproperty
   a_unity: assert property (p_unity) else $error("unity gain alters pixel");

   property p_knee_pass;
      s1_val && gain_clip <= squeeze_knee_level |-> squeezed == gain_clip;
   endproperty
   a_knee_pass: assert property (p_knee_pass) else $error("value below knee changed");

   property p_squeeze_off;
      s1_val && !squeeze_enable |-> squeezed == gain_clip;
   endproperty
   a_squeeze_off: assert property (p_squeeze_off) else $error("squeeze active while off");

   property p_lsb_first;
      busy && bit_idx == 4'h0 && !serial_bit_order |=> serial_bit_out == $past(cur_word[0]);
   endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("first bit not lsb");

   property p_msb_first;
      busy && bit_idx == 4'h0 && serial_bit_order |=>
         serial_bit_out == $past(cur_word[last_idx]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first bit not msb");
endmodule // pixel_output_processing

// >>> test/serial_lane_receiver.sv
// serial pixel receiver model standing in for the camera controller
`timescale 1ns/100ps
module serial_lane_receiver
(
   input wire logic clk_in,
   input wire logic bit_in,
   input wire logic valid_in,
   input wire logic start_in,
   input wire logic dummy_in,
   input wire logic [3:0] lane_in,
   input wire logic msb_first_in,
   input wire logic [3:0] width_in,
   output logic done_out,
   output logic [17:0] word_out
);
   int idx = 0;
   logic [12:0] acc = 13'h0000;
   // width_in only ever carries 10 or 12; the controller never selects code 0
   always @(posedge clk_in)
   begin
      done_out <= 1'b0;
      if (valid_in === 1'b1)
      begin
         if (start_in === 1'b1)
         begin
            idx = 0;
            acc = 13'h0000;
         end
         if (msb_first_in)
            acc[width_in - 1 - idx] = bit_in;
         else
            acc[idx] = bit_in;
         idx++;
         if (idx == int'(width_in))
         begin
            done_out <= 1'b1;
            word_out <= {dummy_in, lane_in, acc};
         end
      end
   end
endmodule // serial_lane_receiver

// >>> test/tb_pixel_output_processing.sv
// self-checking bench for the pixel output path with a serial receiver model
`timescale 1ns/100ps
`include "pixel_output_processing_map.svh"
module tb_pixel_output_processing;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [12:0] reg_wdata = 13'h0000;
   logic [12:0] reg_rdata;
   logic sh_valid = 1'b0;
   logic [12:0] sh_data = 13'h0000;
   logic pix_valid = 1'b0;
   logic pix_ready;
   logic [12:0] pix_data = 13'h0000;
   logic pix_ro = 1'b0;
   logic pix_co = 1'b0;
   logic pix_last = 1'b0;
   logic s_bit, s_valid, s_start, s_dummy, rx_done;
   logic [3:0] s_lane;
   logic [17:0] rx_word;
   logic [17:0] got[$];
   logic [17:0] exp_q[$];
   int ppc = 1;
   int used = 1;
   int wc, order, target, sq_en, knee, sel, byp, black, fixed;
   int gains[4] = '{15, 15, 15, 15};
   int n_errors = 0;
   int compares = 0;

   pixel_output_processing dut
   (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd),
      .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata),
      .reg_rdata_out(reg_rdata),
      .pixels_per_channel_in(14'(ppc)),
      .used_channel_count_in(4'(used)),
      .shield_valid_in(sh_valid),
      .shield_data_in(sh_data),
      .pix_valid_in(pix_valid),
      .pix_ready_out(pix_ready),
      .pix_data_in(pix_data),
      .pix_row_odd_in(pix_ro),
      .pix_col_odd_in(pix_co),
      .pix_row_last_in(pix_last),
      .serial_bit_out(s_bit),
      .serial_valid_out(s_valid),
      .serial_word_start_out(s_start),
      .serial_dummy_out(s_dummy),
      .pixel_serial_lane_out(s_lane)
   );

   serial_lane_receiver rx
   (
      .clk_in(clk_in),
      .bit_in(s_bit),
      .valid_in(s_valid),
      .start_in(s_start),
      .dummy_in(s_dummy),
      .lane_in(s_lane),
      .msb_first_in(order[0]),
      .width_in((wc == 1) ? 4'ha : 4'hc),
      .done_out(rx_done),
      .word_out(rx_word)
   );

   initial
      forever #20 clk_in = ~clk_in;

   always @(negedge clk_in)
   begin
      if (rx_done === 1'b1)
         got.push_back(rx_word);
   end

   task automatic report_and_stop();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp_v);
      compares++;
      if (seen !== exp_v)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp_v, seen);
      end
   endtask

   task automatic reg_write(input logic [6:0] a, input logic [12:0] d);
      @(posedge clk_in);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_in);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [6:0] a, output logic [12:0] d);
      @(posedge clk_in);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      @(negedge clk_in);
      d = reg_rdata;
   endtask

   task automatic set_cfg(input int w, o, t, e, k, s, b, bl, f, p, u);
      wc = w;
      order = o;
      target = t;
      sq_en = e;
      knee = k;
      sel = s;
      byp = b;
      black = bl;
      fixed = f;
      ppc <= p;
      used <= u;
      reg_write(`ADDR_OUTPUT_WORD_WIDTH, 13'(w));
      reg_write(`ADDR_SERIAL_BIT_ORDER, 13'(o));
      reg_write(`ADDR_TARGET_BLACK_LEVEL, 13'(t));
      reg_write(`ADDR_SQUEEZE_ENABLE, 13'(e));
      reg_write(`ADDR_SQUEEZE_KNEE_LEVEL, 13'(k));
      reg_write(`ADDR_SQUEEZE_DIVISOR_SELECT, 13'(s));
      reg_write(`ADDR_BLACK_AUTO_BYPASS, 13'(b));
      reg_write(`ADDR_FIXED_ADC_BLACK_LEVEL, 13'(f));
      for (int i = 0; i < 4; i++)
         reg_write(7'(`ADDR_GAIN_EVEN_ROW_EVEN_COL + i), 13'(gains[i]));
   endtask

   function automatic logic [17:0] exp_word(input int adc, input logic ro, co, input int lane);
      int v;
      int top;
      v = adc - black + target;
      v = (v < 0) ? 0 : ((v > 8191) ? 8191 : v);
      v = v * (gains[{ro, co}] + 1) / 16;
      v = (v > 8191) ? 8191 : v;
      if (sq_en != 0 && v > knee)
         v = knee + ((v - knee) >> (sel + 1));
      top = (wc == 1) ? 1023 : 4095;
      v = (v > top) ? top : v;
      return {1'b0, lane[3:0], v[12:0]};
   endfunction

   task automatic send_pixel(input logic [12:0] d, input logic ro, co, last);
      int n;
      n = 0;
      @(posedge clk_in);
      pix_valid <= 1'b1;
      pix_data <= d;
      pix_ro <= ro;
      pix_co <= co;
      pix_last <= last;
      @(negedge clk_in);
      while (pix_ready !== 1'b1 && n < 500)
      begin
         @(negedge clk_in);
         n++;
      end
      @(posedge clk_in);
      pix_valid <= 1'b0;
   endtask

   // one row of four pixels; lane split and padding predicted from ppc and used
   task automatic run_row(input logic ro, input int v0, v1, v2, v3);
      int v[4];
      int lane;
      int n;
      v = '{v0, v1, v2, v3};
      for (int k = 0; k < 4; k++)
      begin
         lane = (k / ppc < used) ? k / ppc : used - 1;
         exp_q.push_back(exp_word(v[k], ro, k[0], lane));
         send_pixel(13'(v[k]), ro, k[0], k == 3);
      end
      for (int k = 4 - lane * ppc; k < ppc; k++)
         exp_q.push_back({1'b1, lane[3:0], 13'h0000});
      n = 0;
      while (got.size() < exp_q.size() && n < 2000)
      begin
         @(negedge clk_in);
         n++;
      end
      check("word count", 18'(got.size()), 18'(exp_q.size()));
      while (got.size() > 0 && exp_q.size() > 0)
         check("word", got.pop_front(), exp_q.pop_front());
      got.delete();
      exp_q.delete();
   endtask

   task automatic test_registers();
      logic [6:0] a[12] = '{`ADDR_OUTPUT_WORD_WIDTH, `ADDR_SERIAL_BIT_ORDER,
         `ADDR_GAIN_EVEN_ROW_EVEN_COL, `ADDR_GAIN_EVEN_ROW_ODD_COL, `ADDR_GAIN_ODD_ROW_EVEN_COL,
         `ADDR_GAIN_ODD_ROW_ODD_COL, `ADDR_TARGET_BLACK_LEVEL, `ADDR_SQUEEZE_ENABLE,
         `ADDR_SQUEEZE_KNEE_LEVEL, `ADDR_SQUEEZE_DIVISOR_SELECT, `ADDR_BLACK_AUTO_BYPASS,
         `ADDR_FIXED_ADC_BLACK_LEVEL};
      logic [12:0] r[12] = '{`RST_OUTPUT_WORD_WIDTH, `RST_SERIAL_BIT_ORDER, `RST_GAIN, `RST_GAIN,
         `RST_GAIN, `RST_GAIN, `RST_TARGET_BLACK_LEVEL, `RST_SQUEEZE_ENABLE,
         `RST_SQUEEZE_KNEE_LEVEL, `RST_SQUEEZE_DIVISOR_SELECT, `RST_BLACK_AUTO_BYPASS,
         `RST_FIXED_ADC_BLACK_LEVEL};
      logic [12:0] m[12] = '{13'h0003, 13'h0001, 13'h00ff, 13'h00ff, 13'h00ff, 13'h00ff,
         13'h1fff, 13'h0001, 13'h1fff, 13'h0003, 13'h0001, 13'h1fff};
      logic [12:0] d;
      for (int i = 0; i < 12; i++)
      begin
         reg_read(a[i], d);
         check("reset value", 18'(d), 18'(r[i]));
         reg_write(a[i], 13'h1fff);
         reg_read(a[i], d);
         check("read back", 18'(d), 18'(m[i]));
         reg_write(a[i], r[i]);
      end
      reg_write(7'h7f, 13'h1fff);
      reg_read(7'h7f, d);
      check("unmapped read", 18'(d), 18'h0_0000);
   endtask

   // bypass black, all four gains incl. extremes, two lanes, lsb first, 12 bit
   task automatic test_bypass_gain();
      gains = '{15, 31, 0, 255};
      set_cfg(2, 0, 30, 0, 0, 0, 1, 100, 100, 2, 2);
      run_row(1'b0, 50, 600, 700, 800);
      run_row(1'b1, 500, 1000, 1500, 2000);
   endtask

   // every divisor select, msb first, 10 bit, short last lane padded
   task automatic test_squeeze_pad();
      for (int s = 0; s < 4; s++)
      begin
         set_cfg(1, 1, 30, 1, 200, s, 1, 100, 100, 3, 2);
         run_row(s[0], 150, 400, 1200, 3000);
      end
   endtask

   // per-row black from shielded samples, fixed value must be ignored
   task automatic test_auto_black();
      set_cfg(2, 1, 40, 0, 0, 0, 0, 300, 5, 4, 1);
      for (int r = 0; r < 2; r++)
      begin
         for (int i = 0; i < 16; i++)
         begin
            @(posedge clk_in);
            sh_valid <= 1'b1;
            sh_data <= 13'((r == 0) ? 300 : 400 + i % 2);
         end
         @(posedge clk_in);
         sh_valid <= 1'b0;
         black = (r == 0) ? 300 : 400;
         run_row(r[0], 310, 400, 500, 4000);
      end
   endtask

   // all tests take about 800 cycles; the limit leaves a wide margin
   initial
   begin
      repeat (40000) @(posedge clk_in);
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      repeat (10) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      test_registers();
      test_bypass_gain();
      test_squeeze_pad();
      test_auto_black();
      report_and_stop();
   end
endmodule // tb_pixel_output_processing
